// *** hw/ccr_defines.svh ***
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// Register indices (byte address is four times the index)
`define CCR_IDX_SAMP_CLK 8'h2B
`define CCR_IDX_SYNC_POS 8'h2C
`define CCR_IDX_FSR_A 8'h30
`define CCR_IDX_FSR_B 8'h32
`define CCR_IDX_REF_SEL 8'h38
// Reset values
`define CCR_RST_SAMP_CLK 8'h11
`define CCR_RST_SYNC_POS 24'h000000
`define CCR_RST_FSR 16'hA000
`define CCR_RST_REF_SEL 8'h00
// Field positions
`define CCR_BIT_GAIN 4
`define CCR_BIT_NOISE 2
`define CCR_BIT_REFSEL 0
// Range code landmarks
`define CCR_FSR_MIN_REC 16'h2000
`define CCR_FSR_MAX 16'hFFFF
`endif

// *** hw/ccr_pkg.sv ***
package ccr_pkg;
	typedef enum logic [1:0] {CCR_IDLE, CCR_ANSWER} ccr_state_t;
	typedef logic [7:0] ccr_byte_t;
endpackage

// *** hw/ccr_field_if.sv ***
`timescale 1ns/10ps
interface ccr_field_if #(parameter int W = 8);
	logic wrEn;
	logic [W-1:0] wrData;
	logic [W-1:0] value;
	modport owner (input wrEn, input wrData, output value);
	modport user (output wrEn, output wrData, input value);
endinterface

// *** hw/ccr_field.sv ***
`timescale 1ns/10ps
module ccr_field #(parameter int W = 8, parameter logic [W-1:0] RST = '0) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Field access
	ccr_field_if.owner fld
);
	logic [W-1:0] value_reg;
	logic [W-1:0] value_next;
	assign value_next = fld.wrEn ? fld.wrData : value_reg; // see [RULE5]
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			value_reg <= RST;
		else
			value_reg <= value_next;
	end
	assign fld.value = value_reg;
endmodule // ccr_field

// *** hw/ccr_regs.sv ***
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ccr_defines.svh"
// Notes on behaviour
// [RULE1] Sampling clock control resets to 0x11.
// [RULE2] Bit 4 selects converter feedback gain, one is high, resets one.
// [RULE3] Bit 2 enables core supply noise suppression, resets zero.
// [RULE4] Bits 1:0 hold one-hot sampling delay, reset to one.
// [RULE5] Reserved bits reset zero, store and return writes, no effect.
// [RULE6] Capture position returns 24-bit sync edge position in bits 23:0.
// [RULE7] Capture position is read-only, undefined until a capture.
// [RULE8] Software uses capture position to choose the sync delay select.
// [RULE9] Channel A range: 16-bit read-write, resets 0xA000.
// [RULE10] Channel B range: separate 16-bit read-write, resets 0xA000.
// [RULE11] Codes 0x2000, 0xA000, 0xFFFF give 500, 800, 1000 mVPP.
// [RULE12] Software avoids range codes below 0x2000; they are accepted.
// [RULE13] Reference select bit 0 switches reference to core supply.
// [RULE14] Reference select resets to 0x00, band-gap in use.
module ccr_regs
	import ccr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Capture from sync position detector
	input wire logic captureValid,
	input wire logic [23:0] captureValue,
	// Analog controls
	output logic clockConverterGainSelect,
	output logic coreSupplyNoiseSuppress,
	output logic [1:0] samplingDelayOnehot,
	output logic [15:0] fullScaleRangeChanA,
	output logic [15:0] fullScaleRangeChanB,
	output logic referenceSourceSelect,
	output logic syncCaptureDone
);
	ccr_state_t state_reg;
	ccr_state_t state_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;
	logic [23:0] syncPos_reg;
	logic [23:0] syncPos_next;
	logic captured_reg;
	logic [7:0] wordIdx;
	logic aligned;
	logic accept;
	logic doWrite;
	logic hitSamp;
	logic hitPos;
	logic hitFsrA;
	logic hitFsrB;
	logic hitRef;
	logic [31:0] beMask;
	logic [31:0] rdMux;

	ccr_field_if #(.W(8)) sampIf();
	ccr_field_if #(.W(16)) fsrAIf();
	ccr_field_if #(.W(16)) fsrBIf();
	ccr_field_if #(.W(8)) refIf();

	// Address decode
	assign wordIdx = avs_address[9:2];
	assign aligned = (avs_address[1:0] == 2'h0);
	assign hitSamp = aligned && (wordIdx == `CCR_IDX_SAMP_CLK);
	assign hitPos = aligned && (wordIdx == `CCR_IDX_SYNC_POS);
	assign hitFsrA = aligned && (wordIdx == `CCR_IDX_FSR_A);
	assign hitFsrB = aligned && (wordIdx == `CCR_IDX_FSR_B);
	assign hitRef = aligned && (wordIdx == `CCR_IDX_REF_SEL);
	assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// One wait cycle, answer on the second
	assign accept = (state_reg == CCR_IDLE) && (avs_read || avs_write);
	assign doWrite = (state_reg == CCR_ANSWER) && avs_write;
	assign avs_waitrequest = (state_reg != CCR_ANSWER);
	assign state_next = accept ? CCR_ANSWER : CCR_IDLE;

	// Write ports with byte merging
	assign sampIf.wrEn = doWrite && hitSamp && avs_byteenable[0];
	assign sampIf.wrData = avs_writedata[7:0]; // see [RULE5]
	assign fsrAIf.wrEn = doWrite && hitFsrA && (avs_byteenable[1:0] != 2'h0);
	assign fsrAIf.wrData = (avs_writedata[15:0] & beMask[15:0])
		| (fsrAIf.value & ~beMask[15:0]); // see [RULE9]
	assign fsrBIf.wrEn = doWrite && hitFsrB && (avs_byteenable[1:0] != 2'h0);
	assign fsrBIf.wrData = (avs_writedata[15:0] & beMask[15:0])
		| (fsrBIf.value & ~beMask[15:0]); // see [RULE10]
	assign refIf.wrEn = doWrite && hitRef && avs_byteenable[0];
	assign refIf.wrData = avs_writedata[7:0];

	ccr_field #(.W(8), .RST(`CCR_RST_SAMP_CLK)) uSamp ( // see [RULE1]
		.clk(clk),
		.rst_n(rst_n),
		.fld(sampIf.owner)
	);
	ccr_field #(.W(16), .RST(`CCR_RST_FSR)) uFsrA ( // see [RULE9]
		.clk(clk),
		.rst_n(rst_n),
		.fld(fsrAIf.owner)
	);
	ccr_field #(.W(16), .RST(`CCR_RST_FSR)) uFsrB ( // see [RULE10]
		.clk(clk),
		.rst_n(rst_n),
		.fld(fsrBIf.owner)
	);
	ccr_field #(.W(8), .RST(`CCR_RST_REF_SEL)) uRef ( // see [RULE14]
		.clk(clk),
		.rst_n(rst_n),
		.fld(refIf.owner)
	);

	// Capture is hardware-loaded only; bus writes are ignored
	assign syncPos_next = captureValid ? captureValue : syncPos_reg; // see [RULE7]

	// Read selection
	assign rdMux = hitSamp ? {24'h000000, sampIf.value} :
		hitPos ? {8'h00, syncPos_reg} : // see [RULE6]
		hitFsrA ? {16'h0000, fsrAIf.value} :
		hitFsrB ? {16'h0000, fsrBIf.value} :
		hitRef ? {24'h000000, refIf.value} : 32'h00000000;
	assign rdData_next = (accept && avs_read) ? rdMux : rdData_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= CCR_IDLE;
			rdData_reg <= 32'h00000000;
			syncPos_reg <= `CCR_RST_SYNC_POS;
			captured_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			rdData_reg <= rdData_next;
			syncPos_reg <= syncPos_next;
			captured_reg <= captured_reg | captureValid;
		end
	end

	// Analog control outputs
	assign avs_readdata = rdData_reg;
	assign clockConverterGainSelect = sampIf.value[`CCR_BIT_GAIN]; // see [RULE2]
	assign coreSupplyNoiseSuppress = sampIf.value[`CCR_BIT_NOISE]; // see [RULE3]
	assign samplingDelayOnehot = sampIf.value[1:0]; // see [RULE4]
	assign fullScaleRangeChanA = fsrAIf.value; // see [RULE11]
	assign fullScaleRangeChanB = fsrBIf.value; // see [RULE11]
	assign referenceSourceSelect = refIf.value[`CCR_BIT_REFSEL]; // see [RULE13]
	assign syncCaptureDone = captured_reg; // see [RULE7]

	// Checks
	sequence wrSampSeq;
		doWrite && hitSamp && avs_byteenable[0];
	endsequence
	sequence wrFsrASeq;
		doWrite && hitFsrA && (avs_byteenable == 4'hF);
	endsequence
	sequence wrFsrBSeq;
		doWrite && hitFsrB && (avs_byteenable == 4'hF);
	endsequence
	sequence wrRefSeq;
		doWrite && hitRef && avs_byteenable[0];
	endsequence
	sequence wrFsrALoSeq;
		doWrite && hitFsrA && (avs_byteenable[1:0] == 2'h1);
	endsequence
	sequence wrFsrAHiSeq;
		doWrite && hitFsrA && (avs_byteenable[1:0] == 2'h2);
	endsequence
	sequence wrFsrBLoSeq;
		doWrite && hitFsrB && (avs_byteenable[1:0] == 2'h1);
	endsequence
	sequence wrFsrBHiSeq;
		doWrite && hitFsrB && (avs_byteenable[1:0] == 2'h2);
	endsequence
	sequence rdReqSeq;
		accept && avs_read;
	endsequence
	sequence wrPosSeq;
		doWrite && hitPos;
	endsequence

	samp_reset_a: assert property (@(posedge clk) !rst_n |=> sampIf.value == 8'h11) // see [RULE1]
		else $error("sampling clock control reset wrong");
	gain_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrSampSeq |=> clockConverterGainSelect == $past(avs_writedata[4])) // see [RULE2]
		else $error("gain select not following write");
	noise_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrSampSeq |=> coreSupplyNoiseSuppress == $past(avs_writedata[2])) // see [RULE3]
		else $error("noise suppress not following write");
	delay_field_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrSampSeq |=> samplingDelayOnehot == $past(avs_writedata[1:0])) // see [RULE4]
		else $error("sampling delay not following write");
	reserved_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrSampSeq |=> sampIf.value[7:5] == $past(avs_writedata[7:5])) // see [RULE5]
		else $error("reserved bits not stored");
	pos_readonly_a: assert property (@(posedge clk) disable iff (!rst_n)
		!captureValid |=> $stable(syncPos_reg)) // see [RULE7]
		else $error("capture position changed without capture");
	pos_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
		captureValid |=> syncPos_reg == $past(captureValue) && syncCaptureDone) // see [RULE6]
		else $error("capture value not loaded");
	fsr_a_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrFsrASeq |=> fullScaleRangeChanA == $past(avs_writedata[15:0])) // see [RULE9]
		else $error("channel A range write lost");
	fsr_reset_a: assert property (@(posedge clk) !rst_n |=>
		fullScaleRangeChanA == 16'hA000 && fullScaleRangeChanB == 16'hA000) // see [RULE10]
		else $error("range reset wrong");
	ref_reset_a: assert property (@(posedge clk) !rst_n |=> !referenceSourceSelect) // see [RULE14]
		else $error("reference select reset wrong");
	bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	// Sampling clock control
	samp_bit3_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		wrSampSeq |=> sampIf.value[3] == $past(avs_writedata[3]))
		else $error("reserved bit 3 not stored");
	samp_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		!sampIf.wrEn |=> $stable(sampIf.value))
		else $error("sampling clock control changed without write");
	samp_noen_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		doWrite && hitSamp && !avs_byteenable[0] |=> $stable(sampIf.value))
		else $error("sampling clock control written without lane");
	gain_reset_a: assert property (@(posedge clk) // see [RULE2]
		!rst_n |=> clockConverterGainSelect)
		else $error("gain select reset wrong");
	noise_reset_a: assert property (@(posedge clk) // see [RULE3]
		!rst_n |=> !coreSupplyNoiseSuppress)
		else $error("noise suppress reset wrong");
	delay_reset_a: assert property (@(posedge clk) // see [RULE4]
		!rst_n |=> samplingDelayOnehot == 2'h1)
		else $error("sampling delay reset wrong");

	// Full-scale ranges
	fsrb_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		wrFsrBSeq |=> fullScaleRangeChanB == $past(avs_writedata[15:0]))
		else $error("channel B range write lost");
	fsra_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		!fsrAIf.wrEn |=> $stable(fullScaleRangeChanA))
		else $error("channel A range changed without write");
	fsrb_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		!fsrBIf.wrEn |=> $stable(fullScaleRangeChanB))
		else $error("channel B range changed without write");
	fsra_low_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		wrFsrALoSeq |=> fullScaleRangeChanA ==
		{$past(fullScaleRangeChanA[15:8]), $past(avs_writedata[7:0])})
		else $error("channel A low lane merge wrong");
	fsra_high_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		wrFsrAHiSeq |=> fullScaleRangeChanA ==
		{$past(avs_writedata[15:8]), $past(fullScaleRangeChanA[7:0])})
		else $error("channel A high lane merge wrong");
	fsrb_low_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		wrFsrBLoSeq |=> fullScaleRangeChanB ==
		{$past(fullScaleRangeChanB[15:8]), $past(avs_writedata[7:0])})
		else $error("channel B low lane merge wrong");
	fsrb_high_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		wrFsrBHiSeq |=> fullScaleRangeChanB ==
		{$past(avs_writedata[15:8]), $past(fullScaleRangeChanB[7:0])})
		else $error("channel B high lane merge wrong");
	fsra_noen_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		doWrite && hitFsrA && (avs_byteenable[1:0] == 2'h0) |=> $stable(fullScaleRangeChanA))
		else $error("channel A written without lane");
	fsrb_noen_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		doWrite && hitFsrB && (avs_byteenable[1:0] == 2'h0) |=> $stable(fullScaleRangeChanB))
		else $error("channel B written without lane");

	// Reference source select
	ref_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE13]
		wrRefSeq |=> referenceSourceSelect == $past(avs_writedata[0]))
		else $error("reference select write lost");
	ref_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		wrRefSeq |=> refIf.value[7:1] == $past(avs_writedata[7:1]))
		else $error("reference reserved bits not stored");
	ref_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE13]
		!refIf.wrEn |=> $stable(refIf.value))
		else $error("reference select changed without write");
	ref_noen_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE13]
		doWrite && hitRef && !avs_byteenable[0] |=> $stable(refIf.value))
		else $error("reference select written without lane");
	ref_full_reset_a: assert property (@(posedge clk) // see [RULE14]
		!rst_n |=> refIf.value == 8'h00)
		else $error("reference register reset wrong");

	// Capture position
	pos_reset_a: assert property (@(posedge clk) // see [RULE7]
		!rst_n |=> syncPos_reg == 24'h000000)
		else $error("capture position reset wrong");
	pos_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE7]
		wrPosSeq ##0 !captureValid |=> $stable(syncPos_reg))
		else $error("capture position took a bus write");
	done_reset_a: assert property (@(posedge clk) // see [RULE7]
		!rst_n |=> !syncCaptureDone)
		else $error("capture done reset wrong");
	done_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE7]
		syncCaptureDone |=> syncCaptureDone)
		else $error("capture done dropped");

	// Read data
	rd_samp_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE1]
		rdReqSeq ##0 hitSamp |=> avs_readdata == {24'h000000, $past(sampIf.value)})
		else $error("sampling clock control read wrong");
	rd_pos_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
		rdReqSeq ##0 hitPos |=> avs_readdata == {8'h00, $past(syncPos_reg)})
		else $error("capture position read wrong");
	rd_fsra_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		rdReqSeq ##0 hitFsrA |=> avs_readdata == {16'h0000, $past(fsrAIf.value)})
		else $error("channel A range read wrong");
	rd_fsrb_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
		rdReqSeq ##0 hitFsrB |=> avs_readdata == {16'h0000, $past(fsrBIf.value)})
		else $error("channel B range read wrong");
	rd_ref_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE14]
		rdReqSeq ##0 hitRef |=> avs_readdata == {24'h000000, $past(refIf.value)})
		else $error("reference select read wrong");
	rd_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		rdReqSeq ##0 !(hitSamp || hitPos || hitFsrA || hitFsrB || hitRef)
		|=> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	samp_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		rdReqSeq ##0 hitSamp |=> avs_readdata[31:8] == 24'h000000)
		else $error("sampling clock upper bits not zero");
	pos_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
		rdReqSeq ##0 hitPos |=> avs_readdata[31:24] == 8'h00)
		else $error("capture position upper bits not zero");
	fsr_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		rdReqSeq ##0 hitFsrA |=> avs_readdata[31:16] == 16'h0000)
		else $error("channel A upper bits not zero");
	ref_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE14]
		rdReqSeq ##0 hitRef |=> avs_readdata[31:8] == 24'h000000)
		else $error("reference upper bits not zero");
	rd_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(accept && avs_read) |=> $stable(avs_readdata))
		else $error("read data changed without read");
	rd_reset_a: assert property (@(posedge clk)
		!rst_n |=> avs_readdata == 32'h00000000)
		else $error("read data reset wrong");

	// Bus handshake
	wait_idle_a: assert property (@(posedge clk)
		state_reg == CCR_IDLE |-> avs_waitrequest)
		else $error("waitrequest low while idle");
	wait_reset_a: assert property (@(posedge clk)
		!rst_n |=> avs_waitrequest)
		else $error("waitrequest low after reset");
	answer_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	misaligned_wr_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		doWrite && !aligned |=> $stable(sampIf.value) && $stable(refIf.value))
		else $error("misaligned write landed");
endmodule // ccr_regs

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic clk, rst_n, avs_read, avs_write, captureValid, avs_waitrequest;
	logic gain, noise, refSel, capDone;
	logic [1:0] delay;
	logic [3:0] avs_byteenable;
	logic [9:0] avs_address;
	logic [15:0] fsrA, fsrB;
	logic [23:0] captureValue;
	logic [31:0] avs_writedata, avs_readdata, rd;
	int errors = 0;
	int cmpCount = 0;
	ccr_regs DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.captureValid(captureValid), .captureValue(captureValue),
		.clockConverterGainSelect(gain), .coreSupplyNoiseSuppress(noise),
		.samplingDelayOnehot(delay), .fullScaleRangeChanA(fsrA), .fullScaleRangeChanB(fsrB),
		.referenceSourceSelect(refSel), .syncCaptureDone(capDone));
	task automatic complete_run();
		$display("errors %0d, compares %0d", errors, cmpCount);
		if (errors == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle, held until waitrequest is sampled low at a rising edge
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdChk(input logic [9:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 4'hF);
		chk(rd, e);
	endtask
	task automatic tResetVals();
		chk({27'h0, gain, 1'b0, noise, delay}, 32'h11);
		chk({15'h0, refSel, fsrA}, 32'hA000);
		chk({15'h0, capDone, fsrB}, 32'hA000);
		rdChk(10'h0AC, 32'h11);
		rdChk(10'h0B0, 32'h0);
		rdChk(10'h0C0, 32'hA000);
		rdChk(10'h0C8, 32'hA000);
		rdChk(10'h0E0, 32'h0);
	endtask
	task automatic tSampClk();
		xfer(1'b1, 10'h0AC, 32'hEE, 4'hF);
		chk({29'h0, gain, noise, delay}, 32'h6);
		rdChk(10'h0AC, 32'hEE);
		xfer(1'b1, 10'h0AC, 32'h15, 4'h0);
		xfer(1'b1, 10'h0AD, 32'h15, 4'hF);
		rdChk(10'h0AC, 32'hEE);
		xfer(1'b1, 10'h0AC, 32'h11, 4'hF);
		chk({29'h0, gain, noise, delay}, 32'h9);
	endtask
	task automatic tRanges();
		logic [15:0] c[3] = '{16'h2000, 16'hFFFF, 16'h1000};
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, 10'h0C0, {16'hFFFF, c[i]}, 4'hF);
			xfer(1'b1, 10'h0C8, {16'hFFFF, ~c[i]}, 4'hF);
			chk({fsrA, fsrB}, {c[i], ~c[i]});
			rdChk(10'h0C0, {16'h0, c[i]});
			rdChk(10'h0C8, {16'h0, ~c[i]});
		end
		xfer(1'b1, 10'h0C0, 32'h55, 4'h1);
		chk({16'h0, fsrA}, 32'h1055);
	endtask
	task automatic tRefSel();
		xfer(1'b1, 10'h0E0, 32'h01, 4'hF);
		chk({31'h0, refSel}, 32'h1);
		xfer(1'b1, 10'h0E0, 32'hFE, 4'hF);
		chk({31'h0, refSel}, 32'h0);
		rdChk(10'h0E0, 32'hFE);
	endtask
	task automatic tCapture();
		captureValid <= 1'b1;
		captureValue <= 24'h5A3C96;
		@(posedge clk);
		captureValid <= 1'b0;
		captureValue <= 24'hA5C369;
		@(posedge clk);
		chk({31'h0, capDone}, 32'h1);
		rdChk(10'h0B0, 32'h5A3C96);
		xfer(1'b1, 10'h0B0, 32'h123456, 4'hF);
		rdChk(10'h0B0, 32'h5A3C96);
		rdChk(10'h100, 32'h0);
		rdChk(10'h0AD, 32'h0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#3000000;
		errors++;
		complete_run();
	end
	initial
	begin
		rst_n = 1'b0;
		{avs_read, avs_write, captureValid} = 3'h0;
		avs_address = 10'h0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0;
		captureValue = 24'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		tResetVals();
		tSampClk();
		tRanges();
		tRefSel();
		tCapture();
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		tResetVals();
		complete_run();
	end
endmodule // tb_top
